// *** hdl/alarm_pkg.sv ***
// constants, types and helper functions shared by the dual alarm logic
package alarm_pkg;

  // timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned IDLE_TIMEOUT_S = 10;
  localparam logic [3:0] IDLE_TICKS = 4'(IDLE_TIMEOUT_S / TICK_PERIOD_S);
  localparam int unsigned TIME_MAX_S = 3600;

  // widths and ranges
  localparam int unsigned VAL_W = 20;
  localparam int unsigned TIME_W = 12;
  localparam int unsigned CODE_W = 14;
  localparam int unsigned NCH = 2;
  localparam logic signed [21:0] DISP_MAX = 22'sh01869f;
  localparam logic signed [21:0] DISP_MIN = -22'sh01869f;
  localparam logic signed [21:0] CODE_MAX = 22'sh00270f;
  localparam logic signed [21:0] CODE_MIN = 22'sh000000;
  localparam logic [2:0] SP_DIGITS = 3'h5;
  localparam logic [2:0] CODE_DIGITS = 3'h4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SP1 = 8'h04;
  localparam logic [7:0] REG_SP2 = 8'h08;
  localparam logic [7:0] REG_HYST1 = 8'h0c;
  localparam logic [7:0] REG_HYST2 = 8'h10;
  localparam logic [7:0] REG_DELAY1 = 8'h14;
  localparam logic [7:0] REG_DELAY2 = 8'h18;
  localparam logic [7:0] REG_SIL1 = 8'h1c;
  localparam logic [7:0] REG_SIL2 = 8'h20;
  localparam logic [7:0] REG_ACODE = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h30;

  // control fields, channel n at bit n*CH_STRIDE
  localparam int unsigned CH_STRIDE = 4;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_SENSE_LOW = 1;
  localparam int unsigned CTRL_CLOSED_IDLE = 2;
  localparam int unsigned CTRL_ACCESS_EN = 8;
  localparam int unsigned CTRL_FAULT_LO = 9;

  // status fields, channel n at bit n*CH_STRIDE
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_DELAYING = 1;
  localparam int unsigned ST_SILENCED = 2;
  localparam int unsigned ST_SWITCH = 3;
  localparam int unsigned ST_FAULT = 8;
  localparam int unsigned ST_PANEL_LO = 9;

  // interrupt bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_ALARM1 = 0;
  localparam int unsigned IRQ_ALARM2 = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_ABORT = 3;

  // fault loop current in tenths of mA
  localparam logic [7:0] FAULT_MA_LOW_A = 8'h24;
  localparam logic [7:0] FAULT_MA_LOW_B = 8'h26;
  localparam logic [7:0] FAULT_MA_HIGH = 8'hd2;

  // seven sub-functions of one alarm channel
  typedef struct packed {
    logic enable;
    logic signed [VAL_W-1:0] setpoint;
    logic sense_low;
    logic closed_idle;
    logic [VAL_W-1:0] hysteresis;
    logic [TIME_W-1:0] delay_s;
    logic [TIME_W-1:0] silence_s;
  } alarm_cfg_t;

  typedef struct packed {
    logic active;
    logic delaying;
    logic silenced;
    logic switch_closed;
  } chan_status_t;

  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_ACTIVE, CH_SILENCED} chan_state_t;
  typedef enum logic [1:0] {PANEL_DISPLAY, PANEL_CODE, PANEL_SELECT, PANEL_EDIT} panel_state_t;
  typedef enum logic [2:0] {
    MENU_BARGRAPH, MENU_FIRST_ALARM_GROUP, MENU_SECOND_ALARM_GROUP,
    MENU_SETPOINT_ACCESS, MENU_ACCESS_CODE, MENU_OTHER
  } menu_item_t;

  function automatic logic signed [VAL_W-1:0] clamp_val(input logic signed [21:0] v,
                                                       input logic signed [21:0] lo,
                                                       input logic signed [21:0] hi);
    if (v > hi) begin
      return hi[VAL_W-1:0];
    end
    if (v < lo) begin
      return lo[VAL_W-1:0];
    end
    return v[VAL_W-1:0];
  endfunction

  function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v);
    return (v > TIME_MAX_S) ? TIME_W'(TIME_MAX_S) : v[TIME_W-1:0];
  endfunction

  function automatic logic signed [21:0] digit_weight(input logic [2:0] pos);
    case (pos)
      3'h0: return 22'sh000001;
      3'h1: return 22'sh00000a;
      3'h2: return 22'sh000064;
      3'h3: return 22'sh0003e8;
      default: return 22'sh002710;
    endcase
  endfunction

endpackage

// *** hdl/alarm_channel.sv ***
// one alarm channel: hysteresis compare, activation delay, silence
module alarm_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic accept,
  input wire logic signed [19:0] disp_value,
  input wire alarm_pkg::alarm_cfg_t cfg,
  output alarm_pkg::chan_status_t status,
  output logic activated
);
  alarm_pkg::chan_state_t st_q, st_d;
  logic cond_q, cond_d;
  logic sw_q, sw_d;
  logic [alarm_pkg::TIME_W-1:0] cnt_q, cnt_d;
  logic signed [21:0] d_x, sp_x, hy_x;
  logic [alarm_pkg::TIME_W-1:0] cnt_inc;

  assign d_x = 22'(disp_value);
  assign sp_x = 22'(cfg.setpoint);
  assign hy_x = $signed({2'b00, cfg.hysteresis});
  assign cnt_inc = cnt_q + 12'h001;

  always_comb begin
    cond_d = cond_q;
    st_d = st_q;
    cnt_d = cnt_q;
    if (!cfg.enable) begin
      cond_d = 1'b0;
    end else if (!cond_q) begin
      cond_d = cfg.sense_low ? (d_x <= sp_x) : (d_x >= sp_x);
    end else if (cfg.sense_low) begin
      cond_d = !(d_x > sp_x + hy_x);
    end else begin
      cond_d = !(d_x < sp_x - hy_x);
    end
    case (st_q)
      alarm_pkg::CH_IDLE: begin
        cnt_d = '0;
        if (cond_q) begin
          st_d = (cfg.delay_s == '0) ? alarm_pkg::CH_ACTIVE : alarm_pkg::CH_DELAY;
        end
      end
      alarm_pkg::CH_DELAY: begin
        if (!cond_q) begin
          st_d = alarm_pkg::CH_IDLE;
        end else if (tick) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= cfg.delay_s) begin
            st_d = alarm_pkg::CH_ACTIVE;
          end
        end
      end
      alarm_pkg::CH_ACTIVE: begin
        cnt_d = '0;
        if (!cond_q) begin
          st_d = alarm_pkg::CH_IDLE;
        end else if (accept && cfg.silence_s != '0) begin
          st_d = alarm_pkg::CH_SILENCED;
        end
      end
      alarm_pkg::CH_SILENCED: begin
        if (!cond_q) begin
          st_d = alarm_pkg::CH_IDLE;
        end else if (tick) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= cfg.silence_s) begin
            st_d = alarm_pkg::CH_ACTIVE;
          end
        end
      end
      default: st_d = alarm_pkg::CH_IDLE;
    endcase
    if (!cfg.enable) begin
      st_d = alarm_pkg::CH_IDLE;
    end
    sw_d = cfg.closed_idle ^ (st_d == alarm_pkg::CH_ACTIVE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= alarm_pkg::CH_IDLE;
      cond_q <= 1'b0;
      cnt_q <= '0;
      sw_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cond_q <= cond_d;
      cnt_q <= cnt_d;
      sw_q <= sw_d;
    end
  end

  assign activated = (st_d == alarm_pkg::CH_ACTIVE) && (st_q != alarm_pkg::CH_ACTIVE);
  assign status.active = (st_q == alarm_pkg::CH_ACTIVE);
  assign status.delaying = (st_q == alarm_pkg::CH_DELAY);
  assign status.silenced = (st_q == alarm_pkg::CH_SILENCED);
  assign status.switch_closed = sw_q;

endmodule // alarm_channel

// *** hdl/alarm_top.sv ***
// dual alarm logic: registers, keypad setpoint access, fault output, two channels
//
// The placing of the registers and the strobed register port were chosen for this implementation.
module alarm_top #(
  parameter int unsigned TICK_CYCLES = alarm_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [19:0] disp_value,
  input wire logic sensor_fault,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_step,
  input wire logic key_commit,
  input wire logic alarms_fitted,
  input wire alarm_pkg::menu_item_t menu_item,
  output alarm_pkg::menu_item_t menu_next,
  output logic [1:0] alarm_switch_closed,
  output logic [1:0] annunciator,
  output logic display_blink,
  output logic fault_current_force,
  output logic [7:0] fault_current_ma_x10,
  output alarm_pkg::panel_state_t panel_mode,
  output logic signed [19:0] panel_value,
  output logic [2:0] panel_digit,
  output logic panel_second,
  output logic irq
);
  localparam int unsigned NCH = alarm_pkg::NCH;

  // input synchronisers: up, down, step, commit, fitted
  logic [4:0] sync1_q, sync2_q, prev_q;
  logic up_l, dn_l, step_l, fit_l, up_p, dn_p, step_p, com_p, combo_p, any_p;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= {alarms_fitted, key_commit, key_step, key_down, key_up};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign up_l = sync2_q[0];
  assign dn_l = sync2_q[1];
  assign step_l = sync2_q[2];
  assign fit_l = sync2_q[4];
  assign up_p = sync2_q[0] & ~prev_q[0];
  assign dn_p = sync2_q[1] & ~prev_q[1];
  assign step_p = sync2_q[2] & ~prev_q[2];
  assign com_p = sync2_q[3] & ~prev_q[3];
  assign combo_p = (up_l & step_l) & ~(prev_q[0] & prev_q[2]);
  assign any_p = up_p | dn_p | step_p | com_p;

  // one-second tick and half-second blink phase
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick, blink;

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign blink = (tick_cnt_q < 32'(TICK_CYCLES / 2));

  always_comb begin
    tick_cnt_d = tick ? '0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // configuration and interrupt registers
  logic [NCH-1:0] en_q, en_d, sense_q, sense_d, pol_q, pol_d;
  logic acc_en_q, acc_en_d;
  logic [1:0] fsel_q, fsel_d;
  logic signed [19:0] sp_q [NCH], sp_d [NCH];
  logic [19:0] hyst_q [NCH], hyst_d [NCH];
  logic [11:0] dly_q [NCH], dly_d [NCH], sil_q [NCH], sil_d [NCH];
  logic [alarm_pkg::CODE_W-1:0] acode_q, acode_d;
  logic [alarm_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, events;
  logic [31:0] rdata_q, rdata_d, status_word;
  logic sp_store;

  // channels
  alarm_pkg::alarm_cfg_t cfg [NCH];
  alarm_pkg::chan_status_t cst [NCH];
  logic [NCH-1:0] act_p;
  logic accept;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign cfg[i] = '{enable: en_q[i], setpoint: sp_q[i], sense_low: sense_q[i],
                      closed_idle: pol_q[i], hysteresis: hyst_q[i],
                      delay_s: dly_q[i], silence_s: sil_q[i]};
    alarm_channel u_ch (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .accept(accept),
      .disp_value(disp_value),
      .cfg(cfg[i]),
      .status(cst[i]),
      .activated(act_p[i])
    );
    assign alarm_switch_closed[i] = cst[i].switch_closed;
    assign status_word[i*alarm_pkg::CH_STRIDE +: alarm_pkg::CH_STRIDE] = cst[i];
  end

  // keypad setpoint access
  alarm_pkg::panel_state_t pnl_q, pnl_d;
  logic signed [19:0] val_q, val_d;
  logic [2:0] dig_q, dig_d, ndig, wpos;
  logic sel_q, sel_d, abort_p;
  logic [3:0] idle_q, idle_d;
  logic signed [21:0] lo, hi, w;

  assign accept = (pnl_q == alarm_pkg::PANEL_DISPLAY) && step_p && !up_l;

  always_comb begin
    pnl_d = pnl_q;
    val_d = val_q;
    dig_d = dig_q;
    sel_d = sel_q;
    abort_p = 1'b0;
    sp_store = 1'b0;
    ndig = (pnl_q == alarm_pkg::PANEL_CODE) ? alarm_pkg::CODE_DIGITS : alarm_pkg::SP_DIGITS;
    lo = (pnl_q == alarm_pkg::PANEL_CODE) ? alarm_pkg::CODE_MIN : alarm_pkg::DISP_MIN;
    hi = (pnl_q == alarm_pkg::PANEL_CODE) ? alarm_pkg::CODE_MAX : alarm_pkg::DISP_MAX;
    wpos = ndig - 3'h1 - dig_q;
    w = alarm_pkg::digit_weight(wpos);
    idle_d = any_p ? 4'h0 : (tick ? idle_q + 4'h1 : idle_q);
    case (pnl_q)
      alarm_pkg::PANEL_DISPLAY: begin
        idle_d = 4'h0;
        if (combo_p && acc_en_q) begin
          val_d = '0;
          dig_d = '0;
          sel_d = 1'b0;
          pnl_d = (acode_q == '0) ? alarm_pkg::PANEL_SELECT : alarm_pkg::PANEL_CODE;
        end
      end
      alarm_pkg::PANEL_CODE, alarm_pkg::PANEL_EDIT: begin
        if (up_p && !step_l) begin
          val_d = alarm_pkg::clamp_val(22'(val_q) + w, lo, hi);
        end else if (dn_p) begin
          val_d = alarm_pkg::clamp_val(22'(val_q) - w, lo, hi);
        end else if (step_p) begin
          dig_d = (dig_q + 3'h1 >= ndig) ? 3'h0 : dig_q + 3'h1;
        end else if (com_p && pnl_q == alarm_pkg::PANEL_CODE) begin
          if (val_q[alarm_pkg::CODE_W-1:0] == acode_q) begin
            pnl_d = alarm_pkg::PANEL_SELECT;
          end else begin
            pnl_d = alarm_pkg::PANEL_DISPLAY;
            abort_p = 1'b1;
          end
        end else if (com_p) begin
          sp_store = 1'b1;
          pnl_d = alarm_pkg::PANEL_SELECT;
        end
      end
      alarm_pkg::PANEL_SELECT: begin
        if (up_p || dn_p) begin
          sel_d = ~sel_q;
        end else if (step_p) begin
          val_d = sp_q[sel_q];
          dig_d = '0;
          pnl_d = alarm_pkg::PANEL_EDIT;
        end else if (com_p) begin
          pnl_d = alarm_pkg::PANEL_DISPLAY;
        end
      end
      default: pnl_d = alarm_pkg::PANEL_DISPLAY;
    endcase
    if (pnl_q != alarm_pkg::PANEL_DISPLAY && (idle_q >= alarm_pkg::IDLE_TICKS || !acc_en_q)) begin
      pnl_d = alarm_pkg::PANEL_DISPLAY;
      abort_p = 1'b1;
      sp_store = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pnl_q <= alarm_pkg::PANEL_DISPLAY;
      val_q <= '0;
      dig_q <= '0;
      sel_q <= 1'b0;
      idle_q <= '0;
    end else begin
      pnl_q <= pnl_d;
      val_q <= val_d;
      dig_q <= dig_d;
      sel_q <= sel_d;
      idle_q <= idle_d;
    end
  end

  // register writes, reads and interrupt status
  logic fault_prev_q;

  assign events = {abort_p, sensor_fault & ~fault_prev_q, act_p[1], act_p[0]};

  always_comb begin
    en_d = en_q;
    sense_d = sense_q;
    pol_d = pol_q;
    acc_en_d = acc_en_q;
    fsel_d = fsel_q;
    sp_d = sp_q;
    hyst_d = hyst_q;
    dly_d = dly_q;
    sil_d = sil_q;
    acode_d = acode_q;
    imask_d = imask_q;
    ist_d = ist_q;
    if (sp_store) begin
      sp_d[sel_q] = val_q;
    end
    if (reg_wr) begin
      case (reg_addr)
        alarm_pkg::REG_CTRL: begin
          for (int i = 0; i < NCH; i++) begin
            en_d[i] = reg_wdata[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_EN];
            sense_d[i] = reg_wdata[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_SENSE_LOW];
            pol_d[i] = reg_wdata[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_CLOSED_IDLE];
          end
          acc_en_d = reg_wdata[alarm_pkg::CTRL_ACCESS_EN];
          fsel_d = reg_wdata[alarm_pkg::CTRL_FAULT_LO +: 2];
        end
        alarm_pkg::REG_SP1: sp_d[0] = alarm_pkg::clamp_val(22'($signed(reg_wdata[19:0])),
                                                           alarm_pkg::DISP_MIN, alarm_pkg::DISP_MAX);
        alarm_pkg::REG_SP2: sp_d[1] = alarm_pkg::clamp_val(22'($signed(reg_wdata[19:0])),
                                                           alarm_pkg::DISP_MIN, alarm_pkg::DISP_MAX);
        alarm_pkg::REG_HYST1: hyst_d[0] = reg_wdata[19:0];
        alarm_pkg::REG_HYST2: hyst_d[1] = reg_wdata[19:0];
        alarm_pkg::REG_DELAY1: dly_d[0] = alarm_pkg::clamp_time(reg_wdata);
        alarm_pkg::REG_DELAY2: dly_d[1] = alarm_pkg::clamp_time(reg_wdata);
        alarm_pkg::REG_SIL1: sil_d[0] = alarm_pkg::clamp_time(reg_wdata);
        alarm_pkg::REG_SIL2: sil_d[1] = alarm_pkg::clamp_time(reg_wdata);
        alarm_pkg::REG_ACODE: acode_d = (reg_wdata[13:0] > 14'(alarm_pkg::CODE_MAX)) ?
                                        14'(alarm_pkg::CODE_MAX) : reg_wdata[13:0];
        alarm_pkg::REG_IRQ_STAT: ist_d = ist_q & ~reg_wdata[alarm_pkg::IRQ_W-1:0];
        alarm_pkg::REG_IRQ_MASK: imask_d = reg_wdata[alarm_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    ist_d = ist_d | events;
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        alarm_pkg::REG_CTRL: begin
          for (int i = 0; i < NCH; i++) begin
            rdata_d[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_EN] = en_q[i];
            rdata_d[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_SENSE_LOW] = sense_q[i];
            rdata_d[i*alarm_pkg::CH_STRIDE + alarm_pkg::CTRL_CLOSED_IDLE] = pol_q[i];
          end
          rdata_d[alarm_pkg::CTRL_ACCESS_EN] = acc_en_q;
          rdata_d[alarm_pkg::CTRL_FAULT_LO +: 2] = fsel_q;
        end
        alarm_pkg::REG_SP1: rdata_d = 32'(sp_q[0]);
        alarm_pkg::REG_SP2: rdata_d = 32'(sp_q[1]);
        alarm_pkg::REG_HYST1: rdata_d = 32'(hyst_q[0]);
        alarm_pkg::REG_HYST2: rdata_d = 32'(hyst_q[1]);
        alarm_pkg::REG_DELAY1: rdata_d = 32'(dly_q[0]);
        alarm_pkg::REG_DELAY2: rdata_d = 32'(dly_q[1]);
        alarm_pkg::REG_SIL1: rdata_d = 32'(sil_q[0]);
        alarm_pkg::REG_SIL2: rdata_d = 32'(sil_q[1]);
        alarm_pkg::REG_ACODE: rdata_d = 32'(acode_q);
        alarm_pkg::REG_STATUS: rdata_d = status_word;
        alarm_pkg::REG_IRQ_STAT: rdata_d = 32'(ist_q);
        alarm_pkg::REG_IRQ_MASK: rdata_d = 32'(imask_q);
        default: rdata_d = '0;
      endcase
    end
  end

  assign status_word[alarm_pkg::ST_FAULT] = sensor_fault;
  assign status_word[alarm_pkg::ST_PANEL_LO +: 2] = pnl_q;
  assign status_word[31:alarm_pkg::ST_PANEL_LO+2] = '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= '0;
      sense_q <= '0;
      pol_q <= '0;
      acc_en_q <= 1'b0;
      fsel_q <= '0;
      sp_q <= '{default: '0};
      hyst_q <= '{default: '0};
      dly_q <= '{default: '0};
      sil_q <= '{default: '0};
      acode_q <= '0;
      imask_q <= '0;
      ist_q <= '0;
      rdata_q <= '0;
    end else begin
      en_q <= en_d;
      sense_q <= sense_d;
      pol_q <= pol_d;
      acc_en_q <= acc_en_d;
      fsel_q <= fsel_d;
      sp_q <= sp_d;
      hyst_q <= hyst_d;
      dly_q <= dly_d;
      sil_q <= sil_d;
      acode_q <= acode_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      rdata_q <= rdata_d;
    end
  end

  // front-panel outputs, fault current, interrupt
  logic [1:0] ann_d, ann_q;
  logic blink_d, blink_q, force_d, force_q, irq_d, irq_q;
  logic [7:0] ma_d, ma_q;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ann_d[i] = cst[i].active | ((cst[i].delaying | cst[i].silenced) & blink);
    end
    blink_d = sensor_fault & blink;
    force_d = sensor_fault;
    case (fsel_q)
      2'h0: ma_d = alarm_pkg::FAULT_MA_LOW_A;
      2'h1: ma_d = alarm_pkg::FAULT_MA_LOW_B;
      default: ma_d = alarm_pkg::FAULT_MA_HIGH;
    endcase
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ann_q <= '0;
      blink_q <= 1'b0;
      force_q <= 1'b0;
      ma_q <= alarm_pkg::FAULT_MA_LOW_A;
      irq_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      ann_q <= ann_d;
      blink_q <= blink_d;
      force_q <= force_d;
      ma_q <= ma_d;
      irq_q <= irq_d;
      fault_prev_q <= sensor_fault;
    end
  end

  // configuration menu order
  always_comb begin
    case (menu_item)
      alarm_pkg::MENU_BARGRAPH: menu_next = fit_l ? alarm_pkg::MENU_FIRST_ALARM_GROUP :
                                                    alarm_pkg::MENU_ACCESS_CODE;
      alarm_pkg::MENU_FIRST_ALARM_GROUP: menu_next = alarm_pkg::MENU_SECOND_ALARM_GROUP;
      alarm_pkg::MENU_SECOND_ALARM_GROUP: menu_next = alarm_pkg::MENU_SETPOINT_ACCESS;
      alarm_pkg::MENU_SETPOINT_ACCESS: menu_next = alarm_pkg::MENU_ACCESS_CODE;
      alarm_pkg::MENU_ACCESS_CODE: menu_next = alarm_pkg::MENU_OTHER;
      default: menu_next = alarm_pkg::MENU_BARGRAPH;
    endcase
    if (!fit_l && menu_item inside {alarm_pkg::MENU_FIRST_ALARM_GROUP,
        alarm_pkg::MENU_SECOND_ALARM_GROUP, alarm_pkg::MENU_SETPOINT_ACCESS}) begin
      menu_next = alarm_pkg::MENU_ACCESS_CODE;
    end
  end

  assign reg_rdata = rdata_q;
  assign annunciator = ann_q;
  assign display_blink = blink_q;
  assign fault_current_force = force_q;
  assign fault_current_ma_x10 = ma_q;
  assign panel_mode = pnl_q;
  assign panel_value = val_q;
  assign panel_digit = dig_q;
  assign panel_second = sel_q;
  assign irq = irq_q;

endmodule // alarm_top

// *** tb/alarm_top_props.sv ***
// assertions on the dual alarm top-level ports
module alarm_top_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sensor_fault,
  input wire alarm_pkg::menu_item_t menu_item,
  input wire alarm_pkg::menu_item_t menu_next,
  input wire logic display_blink,
  input wire logic fault_current_force,
  input wire logic [7:0] fault_current_ma_x10,
  input wire logic [2:0] panel_digit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence fault_held;
    sensor_fault [*2];
  endsequence
  a_fault_force: assert property (sensor_fault |=> fault_current_force)
    else $error("fault force missing");
  a_fault_clear: assert property (!sensor_fault |=> !fault_current_force)
    else $error("fault force stuck");
  a_force_steady: assert property (fault_held |=> $stable(fault_current_force))
    else $error("fault force dropped");
  a_blink_fault: assert property (display_blink |-> fault_current_force)
    else $error("blink without fault");
  a_fault_level: assert property (fault_current_ma_x10 inside {8'h24, 8'h26, 8'hd2})
    else $error("bad fault current");
  a_digit_range: assert property (panel_digit < 3'h5)
    else $error("digit out of range");
  a_menu_moves: assert property (menu_next != menu_item)
    else $error("menu stuck");
  a_menu_alarm: assert property (menu_item == alarm_pkg::MENU_FIRST_ALARM_GROUP |->
    menu_next == alarm_pkg::MENU_SECOND_ALARM_GROUP) else $error("alarm menu order");
endmodule // alarm_top_props
bind alarm_top alarm_top_props u_props (.clk(clk), .rst_n(rst_n), .sensor_fault(sensor_fault),
  .menu_item(menu_item), .menu_next(menu_next), .display_blink(display_blink),
  .fault_current_force(fault_current_force), .fault_current_ma_x10(fault_current_ma_x10),
  .panel_digit(panel_digit));

// *** tb/keypad_model.sv ***
// operator keypad: holds a key pattern, then releases all keys
module keypad_model (
  input wire logic clk,
  output logic [3:0] keys
);
  timeunit 1ns;
  timeprecision 1ns;
  initial keys = 4'h0;
  task automatic press(input logic [3:0] k);
    @(posedge clk) keys <= k;
    repeat (4) @(posedge clk);
    keys <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule // keypad_model

// *** tb/dual_alarm_logic_test.sv ***
// self-checking bench for the dual alarm logic
module dual_alarm_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sensor_fault = 0, irq;
  logic [7:0] reg_addr = '0, ma;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic signed [19:0] disp_value = '0, pv;
  logic fitted = 1'b1;
  logic [3:0] keys;
  logic [1:0] sw, ann;
  alarm_pkg::menu_item_t menu_item = alarm_pkg::MENU_BARGRAPH, menu_next;
  alarm_pkg::panel_state_t pm;
  int errors = 0, checks = 0;
  always #50 clk = ~clk;
  keypad_model u_keys (.clk(clk), .keys(keys));
  alarm_top #(.TICK_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .disp_value(disp_value), .sensor_fault(sensor_fault), .key_up(keys[3]),
    .key_down(keys[2]), .key_step(keys[1]), .key_commit(keys[0]), .alarms_fitted(fitted),
    .menu_item(menu_item), .menu_next(menu_next), .alarm_switch_closed(sw),
    .annunciator(ann), .display_blink(), .fault_current_force(), .fault_current_ma_x10(ma),
    .panel_mode(pm), .panel_value(pv), .panel_digit(), .panel_second(), .irq(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic ws(input int i, input logic v, input int n);
    for (int k = 0; k < n && sw[i] !== v; k++) @(negedge clk);
    chk(32'(sw[i]), 32'(v));
    if (sw[i] !== v) results();
  endtask
  task automatic t_regs;
    wr(8'h04, 32'h000186a0);
    rd(8'h04, 32'h0001869f);
    rd(8'h3c, 32'h0);
  endtask
  task automatic t_high;
    wr(8'h0c, 32'ha);
    wr(8'h04, 32'h64);
    wr(8'h30, 32'h1);
    wr(8'h00, 32'h1);
    @(posedge clk) disp_value <= 20'sh64;
    ws(0, 1'b1, 6);
    repeat (3) @(negedge clk);
    chk(32'({ann[0], irq}), 32'h3);
    wr(8'h30, 32'h0);
    wr(8'h2c, 32'h1);
    wr(8'h30, 32'h1);
    @(posedge clk) disp_value <= 20'sh5a;
    repeat (4) @(negedge clk);
    chk(32'({sw[0], irq}), 32'h2);
    @(posedge clk) disp_value <= 20'sh59;
    ws(0, 1'b0, 6);
  endtask
  task automatic t_low;
    wr(8'h08, 32'hffffffce);
    wr(8'h00, 32'h70);
    ws(1, 1'b1, 6);
    @(posedge clk) disp_value <= -20'sh32;
    ws(1, 1'b0, 6);
    chk(32'(sw[0]), 32'h0);
    @(posedge clk) disp_value <= -20'sh28;
    ws(1, 1'b1, 6);
  endtask
  task automatic t_delay;
    logic [1:0] seen = '0;
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h1);
    @(posedge clk) disp_value <= 20'sh64;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 15; k++) begin
      @(negedge clk);
      seen[ann[0]] = 1'b1;
    end
    chk(32'(seen), 32'h3);
    chk(32'(sw[0]), 32'h0);
    ws(0, 1'b1, 30);
    wr(8'h1c, 32'h2);
    u_keys.press(4'h2);
    @(negedge clk);
    chk(32'(sw[0]), 32'h0);
    ws(0, 1'b1, 50);
  endtask
  task automatic t_fault;
    @(posedge clk) sensor_fault <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(ma), 32'h24);
    wr(8'h00, 32'h400);
    repeat (2) @(negedge clk);
    chk(32'(ma), 32'hd2);
    wr(8'h00, 32'h200);
    repeat (2) @(negedge clk);
    chk(32'(ma), 32'h26);
    rd(8'h2c, 32'h7);
    @(posedge clk) sensor_fault <= 1'b0;
  endtask
  task automatic t_access;
    wr(8'h00, 32'h100);
    wr(8'h24, 32'h1);
    u_keys.press(4'ha);
    chk(32'(pm), 32'(alarm_pkg::PANEL_CODE));
    u_keys.press(4'h1);
    chk(32'(pm), 32'(alarm_pkg::PANEL_DISPLAY));
    rd(8'h2c, 32'hf);
    wr(8'h24, 32'h0);
    u_keys.press(4'ha);
    chk(32'(pm), 32'(alarm_pkg::PANEL_SELECT));
    u_keys.press(4'h2);
    chk(32'(pm), 32'(alarm_pkg::PANEL_EDIT));
    u_keys.press(4'h8);
    chk(32'(pv), 32'h2774);
    u_keys.press(4'h1);
    chk(32'(pm), 32'(alarm_pkg::PANEL_SELECT));
    u_keys.press(4'h1);
    chk(32'(pm), 32'(alarm_pkg::PANEL_DISPLAY));
    rd(8'h04, 32'h2774);
  endtask
  task automatic t_menu;
    chk(32'(menu_next), 32'(alarm_pkg::MENU_FIRST_ALARM_GROUP));
    @(posedge clk) menu_item <= alarm_pkg::MENU_FIRST_ALARM_GROUP;
    @(negedge clk);
    chk(32'(menu_next), 32'(alarm_pkg::MENU_SECOND_ALARM_GROUP));
    @(posedge clk) menu_item <= alarm_pkg::MENU_BARGRAPH;
    fitted <= 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(menu_next), 32'(alarm_pkg::MENU_ACCESS_CODE));
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_high();
    t_low();
    t_delay();
    t_fault();
    t_access();
    t_menu();
    results();
  end
endmodule // dual_alarm_logic_test
